// [asc_host.v]
// Host-side controller driving an 8192 x 8 asynchronous static memory
`timescale 1ns/1ns
// How the memory behaves and what this block must keep
// RQ1: The memory writes only while low select is low, high select is high and strobe is low.
// RQ2: All three write qualifiers are asserted before any write begins.
// RQ3: A write ends as soon as any one of the three qualifiers drops.
// RQ4: Write data setup and hold are timed against the qualifier that ends the write.
// RQ5: The memory floats its pins when gate high, low select high, strobe low or high select low.
// RQ6: The host never drives the byte bus while the memory drives it.
// RQ7: Each write with the gate low lasts at least float delay plus data setup.
// RQ8: Deselect together with strobe rising keeps the memory outputs floating.
// RQ9: The memory holds 8192 bytes on a 13-bit address and an 8-bit bus.
// RQ10: With both selects active, gate low and strobe high, the memory drives read data.
// RQ11: With either select inactive the memory ignores strobe and gate and stores nothing.
// RQ12: With both selects active and strobe and gate high the memory floats and stores nothing.
`include "asc_defs.vh"
module asc_host (
   input wire SYS_CLK,                       // 20 MHz clock
   input wire RST,                           // Synchronous reset, active high
   input wire REQ_VALID,                     // Request present
   output wire REQ_READY,                    // Request taken this cycle when REQ_VALID is high
   input wire REQ_WRITE,                     // 1 write, 0 read
   input wire [`ASC_ADDR_W-1:0] REQ_ADDR,    // Location
   input wire [`ASC_DATA_W-1:0] REQ_WDATA,   // Write byte
   output reg RSP_VALID,                     // One-cycle pulse at end of access
   output reg [`ASC_DATA_W-1:0] RSP_RDATA,   // Read byte
   output reg [`ASC_ADDR_W-1:0] WORD_SELECT_PINS, // Address pins
   output reg SELECT_LOW_ACTIVE_N,           // Low-active select
   output reg SELECT_HIGH_ACTIVE,            // High-active select
   output reg OUTPUT_GATE_N,                 // Low-active output gate
   output reg WRITE_STROBE_N,                // Low-active write strobe
   input wire [`ASC_DATA_W-1:0] BYTE_BUS_PINS_I, // Byte bus level
   output reg [`ASC_DATA_W-1:0] BYTE_BUS_PINS_O, // Byte bus drive value
   output reg BYTE_BUS_PINS_OE_N             // Low while the host drives
);

   // ****************************************************************
   // States and timing
   // ****************************************************************
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_WSET = 3'h1;
   localparam [2:0] ST_WPULSE = 3'h2;
   localparam [2:0] ST_WEND = 3'h3;
   localparam [2:0] ST_RACC = 3'h4;
   localparam [2:0] ST_RSAMP = 3'h5;
   localparam [2:0] ST_TURN = 3'h6;

   // Counts worked out at integer width, then cut to the counter on purpose
   localparam integer FLOAT_I = `ASC_FLOAT_CYC;
   localparam integer SETUP_I = `ASC_SETUP_CYC;
   localparam integer WCYC_I = `ASC_WCYC_CYC;
   localparam integer READ_I = `ASC_READ_CYC;
   localparam integer TURN_I = `ASC_TURN_CYC;
   localparam integer SYNC_I = `ASC_SYNC_CYC;
   localparam [`ASC_CNT_W-1:0] FLOAT_CYC = FLOAT_I[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] SETUP_CYC = SETUP_I[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] WCYC_CYC = WCYC_I[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] READ_CYC = READ_I[`ASC_CNT_W-1:0];
   localparam [`ASC_CNT_W-1:0] TURN_CYC = TURN_I[`ASC_CNT_W-1:0];
   // Pulse keeps the longer of the two minimums, covering the gate-low case
   localparam [`ASC_CNT_W-1:0] PULSE_SUM = FLOAT_CYC + SETUP_CYC;
   localparam [`ASC_CNT_W-1:0] PULSE_CYC = (PULSE_SUM > WCYC_CYC) ? PULSE_SUM : WCYC_CYC;
   // Two sync flops delay the returning bus
   localparam [`ASC_CNT_W-1:0] SYNC_CYC = SYNC_I[`ASC_CNT_W-1:0];

   function [`ASC_CNT_W-1:0] cnt_dec;
      input [`ASC_CNT_W-1:0] c;
      begin
         cnt_dec = (c == 4'h0) ? 4'h0 : c - 4'h1;
      end
   endfunction

   // Last cycle of a wait; zero counts too so a stuck count cannot hang
   function cnt_done;
      input [`ASC_CNT_W-1:0] c;
      begin
         cnt_done = (c <= 4'h1);
      end
   endfunction

   reg [2:0] state_r, state_nxt;
   reg [`ASC_CNT_W-1:0] cnt_r, cnt_nxt;
   reg [`ASC_DATA_W-1:0] rdata_nxt;
   reg rsp_nxt;
   reg [`ASC_ADDR_W-1:0] addr_nxt;
   reg [`ASC_DATA_W-1:0] wdata_nxt;
   reg sel_n_nxt, sel_h_nxt, gate_n_nxt, strobe_n_nxt, oe_n_nxt;
   wire [`ASC_DATA_W-1:0] bus_sync;

   // ****************************************************************
   // Returning bus, two flops before any logic reads it
   // ****************************************************************
   asc_sync2 u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .d(BYTE_BUS_PINS_I),
      .q(bus_sync)
   );

   // ****************************************************************
   // Request handshake
   // ****************************************************************
   assign REQ_READY = (state_r == ST_IDLE);

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_dec(cnt_r);
      rsp_nxt = 1'b0;
      rdata_nxt = RSP_RDATA;
      addr_nxt = WORD_SELECT_PINS;
      wdata_nxt = BYTE_BUS_PINS_O;
      sel_n_nxt = SELECT_LOW_ACTIVE_N;
      sel_h_nxt = SELECT_HIGH_ACTIVE;
      gate_n_nxt = OUTPUT_GATE_N;
      strobe_n_nxt = WRITE_STROBE_N;
      oe_n_nxt = BYTE_BUS_PINS_OE_N;
      case (state_r)
         ST_IDLE: begin
            // Idle: deselected, nothing stored, bus floats both ways
            sel_n_nxt = 1'b1; // [RQ11]
            sel_h_nxt = 1'b0;
            gate_n_nxt = 1'b1;
            strobe_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            if (REQ_VALID) begin
               addr_nxt = REQ_ADDR; // [RQ9]
               sel_n_nxt = 1'b0;
               sel_h_nxt = 1'b1;
               if (REQ_WRITE) begin
                  // Gate stays high so the memory floats before we drive
                  wdata_nxt = REQ_WDATA;
                  cnt_nxt = FLOAT_CYC;
                  state_nxt = ST_WSET;
               end else begin
                  gate_n_nxt = 1'b0; // [RQ10]
                  cnt_nxt = READ_CYC + SYNC_CYC;
                  state_nxt = ST_RACC;
               end
            end
         end
         ST_WSET: begin
            // Selects and address settle before the strobe falls
            if (cnt_done(cnt_r)) begin
               strobe_n_nxt = 1'b0; // [RQ1] [RQ2]
               oe_n_nxt = 1'b0; // [RQ5] [RQ6]
               cnt_nxt = PULSE_CYC;
               state_nxt = ST_WPULSE;
            end
         end
         ST_WPULSE: begin
            if (cnt_done(cnt_r)) begin
               // Strobe alone ends the write; data is held past that edge
               strobe_n_nxt = 1'b1; // [RQ3] [RQ4] [RQ7]
               state_nxt = ST_WEND;
            end
         end
         ST_WEND: begin
            // Deselect and release only after the strobe edge (zero hold)
            sel_n_nxt = 1'b1; // [RQ8] [RQ4]
            sel_h_nxt = 1'b0;
            oe_n_nxt = 1'b1;
            rsp_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         ST_RACC: begin
            if (cnt_done(cnt_r)) begin
               rdata_nxt = bus_sync;
               state_nxt = ST_RSAMP;
            end
         end
         ST_RSAMP: begin
            // Gate up first; the memory needs time to float before any write
            sel_n_nxt = 1'b1; // [RQ12]
            sel_h_nxt = 1'b0;
            gate_n_nxt = 1'b1;
            rsp_nxt = 1'b1;
            cnt_nxt = TURN_CYC;
            state_nxt = ST_TURN;
         end
         ST_TURN: begin
            if (cnt_done(cnt_r)) begin
               state_nxt = ST_IDLE; // [RQ6]
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Pin and answer registers
   // ****************************************************************
   always @(posedge SYS_CLK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         RSP_VALID <= 1'b0;
         RSP_RDATA <= 8'h00;
         WORD_SELECT_PINS <= 13'h0000;
         BYTE_BUS_PINS_O <= 8'h00;
         SELECT_LOW_ACTIVE_N <= 1'b1;
         SELECT_HIGH_ACTIVE <= 1'b0;
         OUTPUT_GATE_N <= 1'b1;
         WRITE_STROBE_N <= 1'b1;
         BYTE_BUS_PINS_OE_N <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         RSP_VALID <= rsp_nxt;
         RSP_RDATA <= rdata_nxt;
         WORD_SELECT_PINS <= addr_nxt;
         BYTE_BUS_PINS_O <= wdata_nxt;
         SELECT_LOW_ACTIVE_N <= sel_n_nxt;
         SELECT_HIGH_ACTIVE <= sel_h_nxt;
         OUTPUT_GATE_N <= gate_n_nxt;
         WRITE_STROBE_N <= strobe_n_nxt;
         BYTE_BUS_PINS_OE_N <= oe_n_nxt;
      end
   end
endmodule

// [asc_defs.vh]
// Timing constants and widths for the asynchronous SRAM host controller
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define ASC_ADDR_W 13
`define ASC_DATA_W 8
`define ASC_DEPTH 8192

// ****************************************************************
// Times in ns and the clock period
// ****************************************************************
`define ASC_CLK_NS 50
`define ASC_STROBE_TO_FLOAT_NS 8
`define ASC_WRITE_DATA_SETUP_NS 12
`define ASC_WRITE_DATA_HOLD_NS 0
`define ASC_WRITE_CYCLE_MIN_NS 35
`define ASC_READ_ACCESS_NS 35
`define ASC_OUT_FLOAT_NS 10

// Least times round up, never below one cycle
`define ASC_CYC_UP(ns) (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_FLOAT_CYC ((`ASC_CYC_UP(`ASC_STROBE_TO_FLOAT_NS) < 1) ? 1 : \
   `ASC_CYC_UP(`ASC_STROBE_TO_FLOAT_NS))
`define ASC_SETUP_CYC ((`ASC_CYC_UP(`ASC_WRITE_DATA_SETUP_NS) < 1) ? 1 : \
   `ASC_CYC_UP(`ASC_WRITE_DATA_SETUP_NS))
`define ASC_WCYC_CYC ((`ASC_CYC_UP(`ASC_WRITE_CYCLE_MIN_NS) < 1) ? 1 : \
   `ASC_CYC_UP(`ASC_WRITE_CYCLE_MIN_NS))
`define ASC_READ_CYC ((`ASC_CYC_UP(`ASC_READ_ACCESS_NS) < 1) ? 1 : \
   `ASC_CYC_UP(`ASC_READ_ACCESS_NS))
`define ASC_TURN_CYC ((`ASC_CYC_UP(`ASC_OUT_FLOAT_NS) < 1) ? 1 : \
   `ASC_CYC_UP(`ASC_OUT_FLOAT_NS))
// Two flops on the returning bus
`define ASC_SYNC_CYC 2
`define ASC_CNT_W 4

`endif

// [asc_sync2.v]
// Two-flop synchroniser for the returning byte bus pins
`timescale 1ns/1ns
module asc_sync2 (
   input wire clk,                // System clock
   input wire rst,                // Synchronous reset
   input wire [7:0] d,            // Asynchronous input
   output reg [7:0] q             // Synchronised output
);
   reg [7:0] meta_r;
   always @(posedge clk) begin
      if (rst) begin
         meta_r <= 8'h00;
         q <= 8'h00;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// [asc_mem_model.sv]
// Behavioural model of the 8192 x 8 asynchronous static memory
`timescale 1ns/1ns
module asc_mem_model (
   input wire [12:0] addr, // Word select pins
   input wire sel_n, // Low-active select
   input wire sel_h, // High-active select
   input wire gate_n, // Output gate, low active
   input wire strobe_n, // Write strobe, low active
   input wire [7:0] host_d, // Host drive value
   input wire host_oe_n, // Host drive enable, low active
   output wire [7:0] lvl, // Level seen on the byte bus
   output reg clash = 1'b0, // Both sides drove the bus
   output reg [15:0] writes = 16'h0 // Count of stored bytes
);
   reg [7:0] mem [0:8191];
   reg [7:0] last = 8'h00;
   reg wr_on = 1'b0;
   wire wr = ~sel_n & sel_h & ~strobe_n;
   wire rd = ~sel_n & sel_h & ~gate_n & strobe_n;
   // Released bus shows the inverse of its last level, never a stale copy
   assign lvl = !host_oe_n ? host_d : rd ? mem[addr] : ~last;
   always @(lvl) if (!host_oe_n || rd) last = lvl;
   // Store on the first qualifier to drop, data as it stands then
   always @(wr) begin
      if (wr === 1'b1) wr_on = 1'b1;
      else if (wr_on) begin
         mem[addr] = lvl;
         writes = writes + 16'h1;
         wr_on = 1'b0;
      end
   end
   always @(rd or host_oe_n) if (rd && !host_oe_n) clash = 1'b1;
endmodule

// [asc_host_props.sv]
// Assertions on the memory pins and request handshake of the host controller
`timescale 1ns/1ns
module asc_host_props (
   input wire SYS_CLK, // Clock
   input wire RST, // Synchronous reset, active high
   input wire REQ_VALID, // Request present
   input wire REQ_READY, // Request may be taken
   input wire REQ_WRITE, // Write request
   input wire RSP_VALID, // Access done
   input wire SELECT_LOW_ACTIVE_N, // Low-active select
   input wire SELECT_HIGH_ACTIVE, // High-active select
   input wire OUTPUT_GATE_N, // Output gate
   input wire WRITE_STROBE_N, // Write strobe
   input wire BYTE_BUS_PINS_OE_N // Host drive enable
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_wr_start;
      $fell(WRITE_STROBE_N) |-> !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("strobe low while deselected");
   property p_wr_end;
      $rose(WRITE_STROBE_N) |-> ##1 SELECT_LOW_ACTIVE_N && !SELECT_HIGH_ACTIVE && RSP_VALID;
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("write not closed");
   property p_hold; $rose(WRITE_STROBE_N) |-> !BYTE_BUS_PINS_OE_N; endproperty
   a_hold: assert property (p_hold) else $error("data gone at write end");
   property p_pulse;
      $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*2] ##1 WRITE_STROBE_N;
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width wrong");
   property p_gate; !WRITE_STROBE_N |-> OUTPUT_GATE_N; endproperty
   a_gate: assert property (p_gate) else $error("gate low in write");
   property p_contend; !BYTE_BUS_PINS_OE_N |-> OUTPUT_GATE_N; endproperty
   a_contend: assert property (p_contend) else $error("bus contention");
   property p_wr_rsp; REQ_VALID && REQ_READY && REQ_WRITE |-> ##5 RSP_VALID; endproperty
   a_wr_rsp: assert property (p_wr_rsp) else $error("write answer late");
   property p_rd;
      REQ_VALID && REQ_READY && !REQ_WRITE |=> !OUTPUT_GATE_N && WRITE_STROBE_N;
   endproperty
   a_rd: assert property (p_rd) else $error("read not opened");
endmodule
bind asc_host asc_host_props u_props(.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
   .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .RSP_VALID(RSP_VALID),
   .SELECT_LOW_ACTIVE_N(SELECT_LOW_ACTIVE_N), .SELECT_HIGH_ACTIVE(SELECT_HIGH_ACTIVE),
   .OUTPUT_GATE_N(OUTPUT_GATE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
   .BYTE_BUS_PINS_OE_N(BYTE_BUS_PINS_OE_N));

// [testbench.sv]
// Self-checking bench for the asynchronous memory host controller
`timescale 1ns/1ns
module testbench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg rv = 1'b0;
   reg rw = 1'b0;
   reg [12:0] ra = 13'h0;
   reg [7:0] rd = 8'h0;
   reg [7:0] q;
   wire rdy, rsp, sn, sh, gn, wn, oen, clash;
   wire [7:0] rdat, bo, lvl;
   wire [12:0] pa;
   wire [15:0] nwr;
   integer mismatches = 0;
   integer compares = 0;
   integer i;
   always #25 clk = ~clk;
   asc_host i_dut(.SYS_CLK(clk), .RST(rst), .REQ_VALID(rv), .REQ_READY(rdy), .REQ_WRITE(rw),
      .REQ_ADDR(ra), .REQ_WDATA(rd), .RSP_VALID(rsp), .RSP_RDATA(rdat), .WORD_SELECT_PINS(pa),
      .SELECT_LOW_ACTIVE_N(sn), .SELECT_HIGH_ACTIVE(sh), .OUTPUT_GATE_N(gn),
      .WRITE_STROBE_N(wn), .BYTE_BUS_PINS_I(lvl), .BYTE_BUS_PINS_O(bo),
      .BYTE_BUS_PINS_OE_N(oen));
   asc_mem_model i_mem(.addr(pa), .sel_n(sn), .sel_h(sh), .gate_n(gn), .strobe_n(wn),
      .host_d(bo), .host_oe_n(oen), .lvl(lvl), .clash(clash), .writes(nwr));
   task chk(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Request held until an edge that sees ready, answer awaited with a bound
   task acc(input w, input [12:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge clk);
         rv <= 1'b1;
         rw <= w;
         ra <= a;
         rd <= d;
         n = 0;
         @(negedge clk);
         while (rdy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n = n + 1;
         end
         @(posedge clk);
         rv <= 1'b0;
         n = 0;
         @(negedge clk);
         while (rsp !== 1'b1 && n < 20) begin
            @(negedge clk);
            n = n + 1;
         end
         chk(rsp, 1'b1);
         q = rdat;
      end
   endtask
   task t_reset;
      begin
         @(negedge clk);
         chk({sn, sh, gn, wn, oen, rdy}, 6'h2f);
         chk(nwr, 16'h0);
      end
   endtask
   // Both ends of the address space and two alternating-bit addresses, written back to back then read back
   task t_table;
      reg [12:0] ta [0:3];
      reg [7:0] td [0:3];
      begin
         ta[0] = 13'h0000;
         ta[1] = 13'h1fff;
         ta[2] = 13'h0aaa;
         ta[3] = 13'h1555;
         td[0] = 8'ha5;
         td[1] = 8'h3c;
         td[2] = 8'hff;
         td[3] = 8'h00;
         for (i = 0; i < 4; i = i + 1) acc(1'b1, ta[i], td[i]);
         for (i = 0; i < 4; i = i + 1) begin
            acc(1'b0, ta[i], 8'h00);
            chk(q, td[i]);
         end
      end
   endtask
   task t_rewrite;
      begin
         acc(1'b1, 13'h0000, 8'h5a);
         acc(1'b0, 13'h0000, 8'h00);
         chk(q, 8'h5a);
         acc(1'b0, 13'h0000, 8'h00);
         chk(q, 8'h5a);
         chk(nwr, 16'h5);
      end
   endtask
   // Reset lands in the middle of a read; pins go idle and nothing is stored
   task t_midreset;
      begin
         @(posedge clk);
         rv <= 1'b1;
         rw <= 1'b0;
         ra <= 13'h1fff;
         @(posedge clk);
         rv <= 1'b0;
         @(posedge clk);
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         @(negedge clk);
         chk({sn, sh, gn, wn, oen, rdy, rsp}, 7'h5e);
         chk(nwr, 16'h5);
         acc(1'b0, 13'h1fff, 8'h00);
         chk(q, 8'h3c);
      end
   endtask
   task give_verdict;
      begin
         $display("compares=%0d mismatches=%0d", compares, mismatches);
         if (mismatches == 0 && compares > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_table;
      t_rewrite;
      t_midreset;
      chk(clash, 1'b0);
      give_verdict;
   end
   initial begin
      #200000;
      mismatches = mismatches + 1;
      give_verdict;
   end
endmodule
